// *** core/tcape_top.sv ***
// Type-C attach decode and SuperSpeed PHY clock / lane enable control.
// Assumes an external Type-C port controller drives the attach and orientation
// pins as static levels; all pins are asynchronous to clk.
`timescale 1ns/1ps

// Behaviour
// R1: Three arrangements: external mux, mode one, two.
// R2: External mux: three attach inputs mean connection.
// R3: External mux: gate PHY clock until attached.
// R4: Polarity pin sets active level of inputs.
// R5: Mode one when mode select low/floating.
// R6: Mode one decodes two attach, two orientation.
// R7: Mode one enables matching PHY lanes only.
// R8: Port controller reports attach and orientation.
// R9: Synchronise pin inputs before use.
module tcape_top
   import tcape_pkg::*;
#(
   parameter int FILTER = FILTER_CYCLES
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [ATTACH_W-1:0] attach_detect_in,
   input wire logic [ORIENT_W-1:0] orientation_in,
   input wire logic attach_polarity_sel,
   input wire logic mux_mode_select,
   input wire logic ext_mux_sel,
   output logic [ATTACH_W-1:0] ss_phy_clk_en,
   output logic [LANE_W-1:0] ss_phy_lane_en,
   output logic attach_valid,
   output logic [2:0] arrangement
);

   ////////////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic [ATTACH_W-1:0] attach;
      logic [ORIENT_W-1:0] orient;
      tcape_arr_t arr;
      logic [CNT_W-1:0] cnt;
      logic [1:0] warm;
      tcape_st_t st;
      tcape_out_t out;
   } tcape_state_t;

   tcape_state_t state;
   tcape_state_t next_state;

   tcape_pins_t pins_raw;
   tcape_pins_t pins;

   logic [ATTACH_W-1:0] act_attach;
   logic [ORIENT_W-1:0] act_orient;
   tcape_arr_t cand_arr;
   logic changed;
   logic [CNT_W-1:0] filter_last;
   logic any_attach;
   logic [LANE_W-1:0] int_lane;
   logic [ATTACH_W-1:0] int_clk;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation
   // All straps and pins share one synchroniser so a picture moves as a whole
   always_comb begin
      pins_raw.ext_mux_sel = ext_mux_sel;
      pins_raw.mux_mode_select = mux_mode_select;
      pins_raw.attach_polarity_sel = attach_polarity_sel;
      pins_raw.orientation_in = orientation_in;
      pins_raw.attach_detect_in = attach_detect_in;
   end

   tcape_sync #(
      .W(PIN_W)
   ) u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .d(pins_raw), // R9
      .q(pins)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Polarity and arrangement decode
   always_comb begin
      // High polarity select: pins active high; low: active low
      if (pins.attach_polarity_sel) begin
         act_attach = pins.attach_detect_in; // R4
         act_orient = pins.orientation_in; // R4
      end else begin
         act_attach = ~pins.attach_detect_in; // R4
         act_orient = ~pins.orientation_in; // R4
      end
      if (pins.ext_mux_sel) begin
         cand_arr = TCAPE_ARR_EXT; // R1
      end else if (pins.mux_mode_select) begin
         cand_arr = TCAPE_ARR_MODE2; // R1
      end else begin
         cand_arr = TCAPE_ARR_MODE1; // R5
      end
   end

   assign filter_last = (FILTER > 1) ? CNT_W'(FILTER - 1) : '0;
   assign changed = (act_attach != state.attach) || (act_orient != state.orient) || (cand_arr != state.arr);

   ////////////////////////////////////////////////////////////////////////////////
   // Attach summary
   // Internal modes pair attach bit p with orientation bit p; the spare attach
   // input carries no port there and must not raise a valid attach
   always_comb begin
      if (state.arr == TCAPE_ARR_EXT) begin
         any_attach = (state.attach != '0); // R2
      end else begin
         any_attach = (state.attach[PORT_W-1:0] != '0); // R6
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Internal mux lane picture
   // Per port: lane A for normal orientation, lane B for flipped; the spare
   // attach input has no lane pair and its clock stays off
   always_comb begin
      int_lane = LANE_EN_RST;
      int_clk = CLK_EN_RST;
      for (int p = 0; p < PORT_W; p++) begin
         int_lane[2*p+LANE_A] = state.attach[p] & ~state.orient[p]; // R6 R7
         int_lane[2*p+LANE_B] = state.attach[p] & state.orient[p]; // R6 R7
         int_clk[p] = state.attach[p]; // R7
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      next_state = state;

      // Synchroniser holds reset zeros for two edges; under active-low polarity
      // they would decode as a full attach, so nothing is accepted before that
      next_state.warm = {state.warm[0], 1'b1}; // R9

      // Accept the pin picture only after the pins have differed from the held picture for FILTER cycles in a row
      if (!changed || !state.warm[1]) begin
         next_state.cnt = '0;
      end else if (state.cnt >= filter_last) begin
         next_state.cnt = '0;
         next_state.attach = act_attach; // R9
         next_state.orient = act_orient; // R9
         next_state.arr = cand_arr;
      end else begin
         next_state.cnt = state.cnt + CNT_W'(1);
      end

      case (state.st)
         TCAPE_ST_DETACHED: begin
            if (any_attach) begin
               next_state.st = TCAPE_ST_ATTACHED;
            end
         end
         TCAPE_ST_ATTACHED: begin
            if (!any_attach) begin
               next_state.st = TCAPE_ST_DETACHED;
            end
         end
         default: begin
            // Illegal code: fall back to detached with every PHY off
            next_state.st = TCAPE_ST_DETACHED;
         end
      endcase

      // Outputs follow the held picture one edge after the state machine
      next_state.out.arrangement = state.arr;
      next_state.out.attach_valid = (state.st == TCAPE_ST_ATTACHED) && any_attach; // R6
      next_state.out.ss_phy_clk_en = CLK_EN_RST;
      next_state.out.ss_phy_lane_en = LANE_EN_RST;

      if (state.st == TCAPE_ST_ATTACHED) begin
         case (state.arr)
            TCAPE_ARR_EXT: begin
               // One PHY per attach input; clock runs only while attached
               next_state.out.ss_phy_clk_en = state.attach; // R2 R3
               next_state.out.ss_phy_lane_en = LANE_EN_RST;
            end
            TCAPE_ARR_MODE1: begin
               next_state.out.ss_phy_clk_en = int_clk; // R7
               next_state.out.ss_phy_lane_en = int_lane; // R7
            end
            TCAPE_ARR_MODE2: begin
               // Mode two reuses the mode one pin decode
               next_state.out.ss_phy_clk_en = int_clk; // R1
               next_state.out.ss_phy_lane_en = int_lane; // R1
            end
            default: begin
               next_state.out.ss_phy_clk_en = CLK_EN_RST;
               next_state.out.ss_phy_lane_en = LANE_EN_RST;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state.attach <= ATTACH_RST;
         state.orient <= ORIENT_RST;
         state.arr <= TCAPE_ARR_MODE1;
         state.cnt <= '0;
         state.warm <= '0;
         state.st <= TCAPE_ST_DETACHED;
         state.out.ss_phy_clk_en <= CLK_EN_RST;
         state.out.ss_phy_lane_en <= LANE_EN_RST;
         state.out.attach_valid <= 1'b0;
         state.out.arrangement <= TCAPE_ARR_MODE1;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs
   // Straight from the state flops; no logic between them and the pins
   assign ss_phy_clk_en = state.out.ss_phy_clk_en;
   assign ss_phy_lane_en = state.out.ss_phy_lane_en;
   assign attach_valid = state.out.attach_valid;
   assign arrangement = state.out.arrangement;

endmodule : tcape_top

// *** core/tcape_pkg.sv ***
// Package: constants, types and timing for the Type-C attach / PHY enable block.
// Assumes a single 250 MHz core clock.
package tcape_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin counts and field positions
   localparam int ATTACH_W = 3;
   localparam int ORIENT_W = 2;
   localparam int PORT_W = 2;
   localparam int LANE_W = 4;
   localparam int LANE_A = 0;
   localparam int LANE_B = 1;
   localparam int PIN_W = ATTACH_W + ORIENT_W + 3;

   ////////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_PERIOD_PS = 4000;
   localparam int FILTER_TIME_NS = 100;
   localparam int FILTER_CYCLES = (FILTER_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W = 8;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [ATTACH_W-1:0] ATTACH_RST = 3'h0;
   localparam logic [ORIENT_W-1:0] ORIENT_RST = 2'h0;
   localparam logic [ATTACH_W-1:0] CLK_EN_RST = 3'h0;
   localparam logic [LANE_W-1:0] LANE_EN_RST = 4'h0;

   ////////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [2:0] {
      TCAPE_ARR_EXT = 3'h1,
      TCAPE_ARR_MODE1 = 3'h2,
      TCAPE_ARR_MODE2 = 3'h4
   } tcape_arr_t;

   typedef enum logic [1:0] {
      TCAPE_ST_DETACHED = 2'h1,
      TCAPE_ST_ATTACHED = 2'h2
   } tcape_st_t;

   typedef struct packed {
      logic ext_mux_sel;
      logic mux_mode_select;
      logic attach_polarity_sel;
      logic [ORIENT_W-1:0] orientation_in;
      logic [ATTACH_W-1:0] attach_detect_in;
   } tcape_pins_t;

   typedef struct packed {
      logic [ATTACH_W-1:0] ss_phy_clk_en;
      logic [LANE_W-1:0] ss_phy_lane_en;
      logic attach_valid;
      tcape_arr_t arrangement;
   } tcape_out_t;

endpackage : tcape_pkg

// *** core/tcape_sync.sv ***
// Two-flop synchroniser for a bundle of asynchronous pin levels.
// Assumes the inputs are quasi-static levels; no pulse capture.
`timescale 1ns/1ps
module tcape_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [1:0][W-1:0] state;
   logic [1:0][W-1:0] next_state;

   always_comb begin
      next_state[0] = d;
      next_state[1] = state[0];
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign q = state[1];
endmodule : tcape_sync

// *** bench/tcape_top_properties.sv ***
// Checker: output relations of the Type-C attach block.
// Assumes a FILTER equal to the bound design's.
`timescale 1ns/1ps
module tcape_top_properties
   import tcape_pkg::*;
#(
   parameter int FILTER = FILTER_CYCLES
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [ATTACH_W-1:0] attach_detect_in,
   input wire logic [ORIENT_W-1:0] orientation_in,
   input wire logic attach_polarity_sel,
   input wire logic mux_mode_select,
   input wire logic ext_mux_sel,
   input wire logic [ATTACH_W-1:0] ss_phy_clk_en,
   input wire logic [LANE_W-1:0] ss_phy_lane_en,
   input wire logic attach_valid,
   input wire logic [2:0] arrangement
);
   localparam int QUIET = FILTER + 6;
   logic [7:0] quiet;
   logic [7:0] prev;
   logic [7:0] pins;
   logic [10:0] outs;
   logic [1:0] a0;
   assign pins = {attach_detect_in, orientation_in, attach_polarity_sel, mux_mode_select, ext_mux_sel};
   assign outs = {ss_phy_clk_en, ss_phy_lane_en, attach_valid, arrangement};
   assign a0 = {attach_detect_in[0], orientation_in[0]} ~^ {2{attach_polarity_sel}};
   // Cycles since any pin last moved
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         quiet <= 8'h00;
         prev <= 8'h00;
      end else begin
         prev <= pins;
         quiet <= (pins != prev) ? 8'h00 : quiet + {7'h00, quiet != 8'hFF};
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_settled;
      quiet > QUIET;
   endsequence
   property p_reset_vals;
      disable iff (1'b0) !rst_b |-> outs == 11'h002;
   endproperty
   property p_onehot;
      arrangement inside {3'h1, 3'h2, 3'h4};
   endproperty
   property p_ext_lanes;
      arrangement == 3'h1 |-> ss_phy_lane_en == 4'h0 && attach_valid == |ss_phy_clk_en;
   endproperty
   property p_int_clk;
      arrangement != 3'h1 |-> !ss_phy_clk_en[2] && attach_valid == |ss_phy_clk_en[1:0];
   endproperty
   property p_lane_pair;
      arrangement != 3'h1 |-> !(&ss_phy_lane_en[1:0]) && !(&ss_phy_lane_en[3:2])
         && ss_phy_clk_en[1:0] == {|ss_phy_lane_en[3:2], |ss_phy_lane_en[1:0]};
   endproperty
   property p_settle;
      s_settled |-> $stable(outs);
   endproperty
   property p_mode;
      s_settled ##0 !ext_mux_sel |-> arrangement == (mux_mode_select ? 3'h4 : 3'h2);
   endproperty
   property p_ext_clk;
      s_settled ##0 ext_mux_sel |-> arrangement == 3'h1
         && ss_phy_clk_en == (attach_polarity_sel ? attach_detect_in : ~attach_detect_in);
   endproperty
   property p_orient;
      s_settled ##0 !ext_mux_sel |-> ss_phy_lane_en[1:0] == (a0[1] ? (a0[0] ? 2'h2 : 2'h1) : 2'h0);
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("outputs not cleared in reset");
   a_onehot: assert property (p_onehot) else $error("arrangement not one-hot");
   a_ext_lanes: assert property (p_ext_lanes) else $error("external mux lanes or valid wrong");
   a_int_clk: assert property (p_int_clk) else $error("internal mode clock or valid wrong");
   a_lane_pair: assert property (p_lane_pair) else $error("lane pair wrong");
   a_settle: assert property (p_settle) else $error("outputs moved with quiet pins");
   a_mode: assert property (p_mode) else $error("mode select ignored");
   a_ext_clk: assert property (p_ext_clk) else $error("clock gating wrong");
   a_orient: assert property (p_orient) else $error("orientation decode wrong");
endmodule : tcape_top_properties

// *** bench/tcape_pctl_model.sv ***
// Port controller model: drives attach and orientation pins.
// Assumes the bench gives the wanted picture and polarity.
`timescale 1ns/1ps
module tcape_pctl_model
   import tcape_pkg::*;
(
   input wire logic pol,
   input wire logic [ATTACH_W-1:0] att,
   input wire logic [ORIENT_W-1:0] ori,
   output logic [ATTACH_W-1:0] attach_pin,
   output logic [ORIENT_W-1:0] orient_pin
);
   always_comb begin
      attach_pin = pol ? att : ~att;
      orient_pin = pol ? ori : ~ori;
   end
endmodule : tcape_pctl_model

// *** bench/typec_attach_phy_enable_tb.sv ***
// Testbench: random and corner pin pictures, outputs checked.
// Assumes FILTER of 2 and a pulled-down mode pin.
`timescale 1ns/1ps
module typec_attach_phy_enable_tb;
   import tcape_pkg::*;
   logic clk = 0, rst_b = 1, pol = 1, ext = 1, mode = 0, flt = 0;
   logic [2:0] att = 0, apin, ce, arr;
   logic [1:0] ori = 0, opin;
   logic [3:0] lane;
   logic valid;
   logic [10:0] outs;
   logic mode_pin;
   int fails = 0, n_checks = 0, i;
   localparam int FILT = 2;
   localparam int LAT = FILT + 4;
   assign mode_pin = flt ? 1'b0 : mode; // Floating pin reads as its pull-down level
   assign outs = {ce, lane, valid, arr};
   initial forever #2 clk = ~clk;
   tcape_pctl_model pc (.pol(pol), .att(att), .ori(ori), .attach_pin(apin), .orient_pin(opin));
   tcape_top #(.FILTER(FILT)) dut (.clk(clk), .rst_b(rst_b), .attach_detect_in(apin), .orientation_in(opin),
      .attach_polarity_sel(pol), .mux_mode_select(mode_pin), .ext_mux_sel(ext), .ss_phy_clk_en(ce),
      .ss_phy_lane_en(lane), .attach_valid(valid), .arrangement(arr));
   function automatic logic [10:0] expect_out();
      logic [3:0] l;
      l = 4'h0;
      if (ext) return {att, 4'h0, |att, 3'h1};
      for (int p = 0; p < 2; p++) l[2*p+ori[p]] = att[p];
      return {1'b0, att[1:0], l, |att[1:0], (mode && !flt) ? 3'h4 : 3'h2};
   endfunction
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input logic [10:0] seen, input logic [10:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // Outputs must stand at the new picture FILTER+4 edges after a pin change
   task automatic settle();
      repeat (LAT) @(negedge clk);
   endtask
   initial begin
      void'($urandom(32'h311AD8AB));
      #1 rst_b = 0;
      repeat (10) @(negedge clk);
      check(outs, 11'h002);
      rst_b = 1;
      {ext, flt, mode, att, ori, pol} = 9'h0E2;
      repeat (LAT) begin
         @(negedge clk);
         check(outs, 11'h002);
      end
      check(outs, expect_out());
      for (i = 0; i < 80; i++) begin
         @(negedge clk);
         {ext, mode, flt, att, ori, pol} = 9'($urandom);
         settle();
         check(outs, expect_out());
      end
      rst_b = 0;
      @(negedge clk);
      check(outs, 11'h002);
      rst_b = 1;
      settle();
      check(outs, expect_out());
      att = ~att;
      @(negedge clk);
      att = ~att;
      repeat (6) begin
         @(negedge clk);
         check(outs, expect_out());
      end
      final_report();
   end
endmodule : typec_attach_phy_enable_tb
bind tcape_top tcape_top_properties #(.FILTER(FILTER)) u_props (.clk(clk), .rst_b(rst_b),
   .attach_detect_in(attach_detect_in), .orientation_in(orientation_in), .attach_polarity_sel(attach_polarity_sel),
   .mux_mode_select(mux_mode_select), .ext_mux_sel(ext_mux_sel), .ss_phy_clk_en(ss_phy_clk_en),
   .ss_phy_lane_en(ss_phy_lane_en), .attach_valid(attach_valid), .arrangement(arrangement));
